// *** sse_defines.vh ***
// Register map, field positions and timing constants of the sequencer
`ifndef SSE_DEFINES_VH
`define SSE_DEFINES_VH
// Clock and timebase
`define SSE_CLK_HZ 25000000
`define SSE_US_PER_TICK 10
`define SSE_US_CYC (`SSE_CLK_HZ / 1000000)
`define SSE_TICK_CYC (`SSE_US_CYC * `SSE_US_PER_TICK)
`define SSE_OSC_HZ 100000
`define SSE_OSC_HALF (`SSE_CLK_HZ / (2 * `SSE_OSC_HZ))
// Clamps sized to the 7-bit filter and pulse fields and to the 16-bit timer counters
`define SSE_FILT_MAX_US 7'h64
`define SSE_PULSE_MAX_US 7'h64
`define SSE_TIMER_MAX_MS 400
`define SSE_TIMER_MAX (`SSE_TIMER_MAX_MS * 1000 / `SSE_US_PER_TICK)
// Register byte offsets
`define SSE_REG_CTRL 12'h000
`define SSE_REG_AUX_MODE 12'h004
`define SSE_REG_PULSE 12'h008
`define SSE_REG_DRV_SRC 12'h00c
`define SSE_REG_DRV_HOST 12'h010
`define SSE_REG_DRV_MODE 12'h014
`define SSE_REG_CFG 12'h018
`define SSE_REG_STATUS 12'h01c
`define SSE_REG_INPUTS 12'h020
`define SSE_REG_FILT_BASE 12'h040
`define SSE_REG_CELL_BASE 12'h400
// Control register fields
`define SSE_CTRL_RUN 0
`define SSE_CTRL_JUMP 1
`define SSE_CTRL_TGT_LO 8
// Aux mode fields
`define SSE_AUX_EDGE_LO 8
// Driver source codes
`define SSE_SRC_ENGINE 2'h0
`define SSE_SRC_HOST 2'h1
`define SSE_SRC_OSC 2'h2
// Cell word A fields
`define SSE_A_SEL_LO 0
`define SSE_A_POL 4
`define SSE_A_TWARN 5
`define SSE_A_SEQ_LO 8
`define SSE_A_MON_LO 16
`define SSE_A_TMO_LO 24
`define SSE_A_TEN 31
// Cell word B and C fields
`define SSE_B_TMO_LO 16
`define SSE_C_MASK_LO 16
// Sequence select code for the combined warning
`define SSE_SEL_WARN 4'ha
// AXI responses
`define SSE_RESP_OKAY 2'h0
`define SSE_RESP_SLVERR 2'h2
`endif

// *** sse_props.sv ***
// Bus and output checker bound to the sequencer top
`timescale 1ns/1ps
`default_nettype none
module sse_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_rresp,
  input wire [9:0] driver_active,
  input wire [9:0] driver_pump
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_pump;
    driver_pump[9:6] == 4'h0;
  endproperty
  a_pump: assert property (p_pump) else $error("pump on high output");
  property p_rst;
    $rose(aresetn) |-> driver_active == 10'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("active after reset");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_wref;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wref: assert property (p_wref) else $error("write ready early");
  property p_rref;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rref: assert property (p_rref) else $error("read ready early");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_bend;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  a_bend: assert property (p_bend) else $error("write end wrong");
endmodule // sse_props
bind sse_top sse_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp), .driver_active(driver_active),
  .driver_pump(driver_pump));
`default_nettype wire

// *** sse_regulators.sv ***
// Board regulators whose good signals follow their enables
`timescale 1ns/1ps
`default_nettype none
module sse_regulators #(parameter int RAMP = 50) (
  input wire logic aclk,
  input wire logic [9:0] driver_output,
  output logic [4:0] primary_detect_ok
);
  logic [4:0] pipe [RAMP] = '{default: 5'h0};
  // Ramp delay, so the engine cannot see power good at once
  always @(posedge aclk) begin
    pipe[0] <= driver_output[4:0];
    for (int i = 1; i < RAMP; i++) pipe[i] <= pipe[i-1];
  end
  assign primary_detect_ok = pipe[RAMP-1];
endmodule // sse_regulators
`default_nettype wire

// *** sse_top.v ***
// Supply sequencing engine core with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "sse_defines.vh"

module sse_top #(
  parameter NCELL = 63,
  parameter NIN = 10,
  parameter NAUX = 5,
  parameter NOUT = 10,
  parameter NPUMP = 6
) (
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NAUX-1:0] primary_detect_ok,
  input wire [NAUX-1:0] aux_detect_ok,
  input wire [NAUX-1:0] aux_dual_input,
  output reg [NOUT-1:0] driver_output,
  output reg [NOUT-1:0] driver_active,
  output reg [NOUT-1:0] driver_pump
);

  // ****************************************
  // Decode helpers
  // ****************************************
  // Byte-lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // Cell region hit: base window, index below cell count, word 0..2
  function cell_hit;
    input [11:0] a;
    begin
      cell_hit = (a[11:10] == `SSE_REG_CELL_BASE >> 10) &&
        (a[9:4] < NCELL) && (a[3:2] != 2'h3);
    end
  endfunction

  // Filter register hit: one word per input
  function filt_hit;
    input [11:0] a;
    begin
      filt_hit = (a[11:6] == `SSE_REG_FILT_BASE >> 6) &&
        (a[5:2] < NIN);
    end
  endfunction

  // ****************************************
  // Configuration registers
  // ****************************************
  reg run;
  reg jump_req;
  reg [5:0] jump_tgt;
  reg [NAUX-1:0] aux_digital;
  reg [NAUX-1:0] aux_edge;
  reg [6:0] pulse_us;
  reg [2*NOUT-1:0] drv_src;
  reg [NOUT-1:0] drv_host;
  reg [NPUMP-1:0] drv_mode;
  reg cfg_latched;
  reg [6:0] filt_us [0:NIN-1];
  reg [31:0] cell_a [0:NCELL-1];
  reg [31:0] cell_b [0:NCELL-1];
  reg [31:0] cell_c [0:NCELL-1];
  reg [5:0] cur;
  wire [NIN-1:0] eng_in;
  wire [NAUX-1:0] warn;
  wire warn_or;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  reg aw_held;
  reg w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write;
  wire [31:0] src_merged;
  wire [31:0] host_merged;
  integer k;

  // Write fires once both halves are held and no response waits
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Byte-lane merges of the narrow driver registers
  assign src_merged = merge({12'h000, drv_src}, w_data, w_strb);
  assign host_merged = merge({22'h000000, drv_host}, w_data, w_strb);

  // Address and data accepted in either order, one write at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSE_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[11:2] <= `SSE_REG_INPUTS >> 2 ||
          filt_hit(aw_addr) || cell_hit(aw_addr)) ?
          `SSE_RESP_OKAY : `SSE_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register updates; every field clears to zero on reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      run <= 1'b0;
      jump_req <= 1'b0;
      jump_tgt <= 6'h00;
      aux_digital <= {NAUX{1'b0}};
      aux_edge <= {NAUX{1'b0}};
      pulse_us <= 7'h00;
      drv_src <= {2*NOUT{1'b0}};
      drv_host <= {NOUT{1'b0}};
      drv_mode <= {NPUMP{1'b0}};
      cfg_latched <= 1'b0;
      for (k = 0; k < NIN; k = k + 1) begin
        filt_us[k] <= 7'h00;
      end
      for (k = 0; k < NCELL; k = k + 1) begin
        cell_a[k] <= 32'h00000000;
        cell_b[k] <= 32'h00000000;
        cell_c[k] <= 32'h00000000;
      end
    end else if (clk_en) begin
      jump_req <= 1'b0; // Jump is a one-shot command
      if (do_write) begin
        case (aw_addr)
          `SSE_REG_CTRL: begin
            run <= w_strb[0] ? w_data[`SSE_CTRL_RUN] : run;
            jump_req <= w_strb[0] & w_data[`SSE_CTRL_JUMP];
            jump_tgt <= w_strb[1] ? w_data[`SSE_CTRL_TGT_LO +: 6] : jump_tgt;
          end
          `SSE_REG_AUX_MODE: begin
            aux_digital <= w_strb[0] ? w_data[NAUX-1:0] : aux_digital;
            aux_edge <= w_strb[1] ? w_data[`SSE_AUX_EDGE_LO +: NAUX] :
              aux_edge;
          end
          `SSE_REG_PULSE: begin
            if (w_strb[0]) begin
              pulse_us <= (w_data[6:0] > `SSE_PULSE_MAX_US) ?
                `SSE_PULSE_MAX_US : w_data[6:0];
            end
          end
          `SSE_REG_DRV_SRC: begin
            drv_src <= src_merged[2*NOUT-1:0];
          end
          `SSE_REG_DRV_HOST: begin
            drv_host <= host_merged[NOUT-1:0];
          end
          `SSE_REG_DRV_MODE: begin
            drv_mode <= w_strb[0] ? w_data[NPUMP-1:0] : drv_mode;
          end
          `SSE_REG_CFG: begin
            cfg_latched <= w_strb[0] ? w_data[0] : cfg_latched;
          end
          default: begin
            if (filt_hit(aw_addr) && w_strb[0]) begin
              filt_us[aw_addr[5:2]] <= (w_data[6:0] > `SSE_FILT_MAX_US) ?
                `SSE_FILT_MAX_US : w_data[6:0];
            end
            if (cell_hit(aw_addr)) begin
              case (aw_addr[3:2])
                2'h0: cell_a[aw_addr[9:4]] <=
                  merge(cell_a[aw_addr[9:4]], w_data, w_strb);
                2'h1: cell_b[aw_addr[9:4]] <=
                  merge(cell_b[aw_addr[9:4]], w_data, w_strb);
                default: cell_c[aw_addr[9:4]] <=
                  merge(cell_c[aw_addr[9:4]], w_data, w_strb);
              endcase
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  reg [31:0] rd_word;

  // Read mux; unmapped words read zero with an error answer
  always @* begin
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      `SSE_REG_CTRL: rd_word = {18'h00000, jump_tgt, 7'h00, run};
      `SSE_REG_AUX_MODE: rd_word = {19'h00000, aux_edge, 3'h0, aux_digital};
      `SSE_REG_PULSE: rd_word = {25'h0000000, pulse_us};
      `SSE_REG_DRV_SRC: rd_word = {12'h000, drv_src};
      `SSE_REG_DRV_HOST: rd_word = {22'h000000, drv_host};
      `SSE_REG_DRV_MODE: rd_word = {26'h0000000, drv_mode};
      `SSE_REG_CFG: rd_word = {31'h00000000, cfg_latched};
      `SSE_REG_STATUS: rd_word = {18'h00000, 1'b0, warn, 1'b0, warn_or, cur};
      `SSE_REG_INPUTS: rd_word = {22'h000000, eng_in};
      default: begin
        if (filt_hit(s_axi_araddr)) begin
          rd_word = {25'h0000000, filt_us[s_axi_araddr[5:2]]};
        end else if (cell_hit(s_axi_araddr)) begin
          case (s_axi_araddr[3:2])
            2'h0: rd_word = cell_a[s_axi_araddr[9:4]];
            2'h1: rd_word = cell_b[s_axi_araddr[9:4]];
            default: rd_word = cell_c[s_axi_araddr[9:4]];
          endcase
        end
      end
    endcase
  end

  // One read in flight; answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SSE_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (s_axi_araddr[11:2] <= `SSE_REG_INPUTS >> 2 ||
          filt_hit(s_axi_araddr) || cell_hit(s_axi_araddr)) ?
          `SSE_RESP_OKAY : `SSE_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Shared timebase and 100 kHz clock
  // ****************************************
  reg [4:0] us_div;
  reg [3:0] tick_div;
  reg us_tick;
  reg tick10;
  reg [7:0] osc_div;
  reg osc;

  always @(posedge aclk) begin
    if (!aresetn) begin
      us_div <= 5'h00;
      tick_div <= 4'h0;
      us_tick <= 1'b0;
      tick10 <= 1'b0;
      osc_div <= 8'h00;
      osc <= 1'b0;
    end else if (clk_en) begin
      us_tick <= (us_div == `SSE_US_CYC - 1);
      tick10 <= (us_div == `SSE_US_CYC - 1) &&
        (tick_div == `SSE_US_PER_TICK - 1);
      if (us_div == `SSE_US_CYC - 1) begin
        us_div <= 5'h00;
        tick_div <= (tick_div == `SSE_US_PER_TICK - 1) ? 4'h0 :
          tick_div + 4'h1;
      end else begin
        us_div <= us_div + 5'h01;
      end
      if (osc_div == `SSE_OSC_HALF - 1) begin
        osc_div <= 8'h00;
        osc <= ~osc;
      end else begin
        osc_div <= osc_div + 8'h01;
      end
    end
  end

  // ****************************************
  // Input conditioning
  // ****************************************
  // Channels 0..9 feed the engine, 10..14 are warning detectors
  wire [14:0] raw;
  wire [14:0] filt;
  genvar g;

  generate
    for (g = 0; g < 15; g = g + 1) begin : g_filt
      reg fo;
      reg [6:0] fc;
      wire [6:0] lim;
      if (g < NAUX) begin : g_pri
        assign raw[g] = primary_detect_ok[g];
        assign lim = filt_us[g];
      end else if (g < NIN) begin : g_aux
        assign raw[g] = aux_digital[g-NAUX] ? aux_dual_input[g-NAUX] :
          aux_detect_ok[g-NAUX];
        assign lim = filt_us[g];
      end else begin : g_warn
        assign raw[g] = aux_detect_ok[g-NIN];
        assign lim = filt_us[g-NIN];
      end
      // pass only after holding lim us
      always @(posedge aclk) begin
        if (!aresetn) begin
          fo <= 1'b0;
          fc <= 7'h00;
        end else if (clk_en) begin
          if (raw[g] == fo) begin
            fc <= 7'h00;
          end else if (fc >= lim) begin
            fo <= raw[g];
            fc <= 7'h00;
          end else if (us_tick) begin
            fc <= fc + 7'h01;
          end
        end
      end
      assign filt[g] = fo;
    end

    // Digital block per aux input: level or edge pulse
    for (g = 0; g < NAUX; g = g + 1) begin : g_dig
      reg ein_aux;
      reg ein_pri;
      reg wbit;
      reg prev;
      reg pls;
      reg [6:0] pc;
      always @(posedge aclk) begin
        if (!aresetn) begin
          prev <= 1'b0;
          pls <= 1'b0;
          pc <= 7'h00;
        end else if (clk_en) begin
          prev <= filt[NAUX+g];
          if (prev != filt[NAUX+g]) begin
            pls <= 1'b1;
            pc <= pulse_us;
          end else if (pc == 7'h00) begin
            pls <= 1'b0;
          end else if (us_tick) begin
            pc <= pc - 7'h01;
          end
        end
      end
      always @(posedge aclk) begin
        if (!aresetn) begin
          ein_aux <= 1'b0;
          wbit <= 1'b0;
        end else if (clk_en) begin
          ein_aux <= (aux_digital[g] & aux_edge[g]) ? pls :
            filt[NAUX+g];
          wbit <= aux_digital[g] & ~filt[NIN+g];
        end
      end
      always @(posedge aclk) begin
        if (!aresetn) begin
          ein_pri <= 1'b0;
        end else if (clk_en) begin
          ein_pri <= filt[g];
        end
      end
      // Per-bit flops keep one driver per engine input
      assign eng_in[NAUX+g] = ein_aux;
      assign eng_in[g] = ein_pri;
      assign warn[g] = wbit;
    end
  endgenerate

  assign warn_or = |warn;

  // ****************************************
  // Sequencing engine
  // ****************************************
  localparam ST_HOLD = 2'b01;
  localparam ST_RUN = 2'b10;
  reg [1:0] eng_st;
  reg [15:0] seq_cnt;
  reg [15:0] tmo_cnt;
  wire [31:0] ca;
  wire [31:0] cb;
  wire [31:0] cc;
  wire [3:0] sel;
  wire sel_val;
  wire seq_met;
  wire seq_fire;
  wire mon_fire;
  wire tmo_fire;

  assign ca = cell_a[cur];
  assign cb = cell_b[cur];
  assign cc = cell_c[cur];
  assign sel = ca[`SSE_A_SEL_LO +: 4];
  // any of ten inputs; warning selectable
  assign sel_val = (sel == `SSE_SEL_WARN) ? warn_or :
    (sel < NIN) ? eng_in[sel] : 1'b0;
  assign seq_met = (sel_val == ca[`SSE_A_POL]);
  assign seq_fire = seq_met && (seq_cnt >= cb[15:0]);
  // monitor: any masked input not ok, or masked warning
  assign mon_fire = |(cc[`SSE_C_MASK_LO +: NIN+1] & {warn_or, ~eng_in});
  assign tmo_fire = (ca[`SSE_A_TEN] && tmo_cnt >= cb[`SSE_B_TMO_LO +: 16]) ||
    (ca[`SSE_A_TWARN] && warn_or);

  // Monitor wins over sequence, sequence over timeout; host jump first
  always @(posedge aclk) begin
    if (!aresetn) begin
      eng_st <= ST_HOLD;
      cur <= 6'h00;
      seq_cnt <= 16'h0000;
      tmo_cnt <= 16'h0000;
    end else if (clk_en) begin
      case (eng_st)
        ST_HOLD: begin
          seq_cnt <= 16'h0000;
          tmo_cnt <= 16'h0000;
          if (jump_req) begin
            cur <= jump_tgt;
          end
          eng_st <= run ? ST_RUN : ST_HOLD;
        end
        ST_RUN: begin
          if (jump_req || mon_fire || seq_fire || tmo_fire) begin
            cur <= jump_req ? jump_tgt :
              mon_fire ? ca[`SSE_A_MON_LO +: 6] :
              seq_fire ? ca[`SSE_A_SEQ_LO +: 6] : ca[`SSE_A_TMO_LO +: 6];
            seq_cnt <= 16'h0000;
            tmo_cnt <= 16'h0000;
          end else begin
            if (!seq_met) begin
              seq_cnt <= 16'h0000;
            end else if (tick10 && seq_cnt < `SSE_TIMER_MAX) begin
              seq_cnt <= seq_cnt + 16'h0001;
            end
            if (tick10 && tmo_cnt < `SSE_TIMER_MAX) begin
              tmo_cnt <= tmo_cnt + 16'h0001;
            end
          end
          eng_st <= run ? ST_RUN : ST_HOLD;
        end
        default: eng_st <= ST_HOLD;
      endcase
    end
  end

  // ****************************************
  // Driver output selection
  // ****************************************
  integer d;
  wire [NOUT-1:0] pump_sel;

  // Pump bits padded so high outputs never index past the field
  assign pump_sel = {{(NOUT-NPUMP){1'b0}}, drv_mode};

  // Until configuration is latched every output is weakly pulled low
  always @(posedge aclk) begin
    if (!aresetn) begin
      driver_output <= {NOUT{1'b0}};
      driver_active <= {NOUT{1'b0}};
      driver_pump <= {NOUT{1'b0}};
    end else if (clk_en) begin
      for (d = 0; d < NOUT; d = d + 1) begin
        case (drv_src[2*d +: 2])
          `SSE_SRC_ENGINE: driver_output[d] <= cfg_latched & cc[d];
          `SSE_SRC_HOST: driver_output[d] <= cfg_latched & drv_host[d];
          `SSE_SRC_OSC: driver_output[d] <= cfg_latched & osc;
          default: driver_output[d] <= 1'b0;
        endcase
        driver_active[d] <= cfg_latched;
        driver_pump[d] <= (d < NPUMP) ? cfg_latched & pump_sel[d] : 1'b0;
      end
    end
  end

endmodule // sse_top
`default_nettype wire

// *** supply_sequencing_engine_bench.sv ***
// Self-checking bench of the supply sequencing engine
`timescale 1ns/1ps
`default_nettype none
`include "sse_defines.vh"
module supply_sequencing_engine_bench;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] awaddr = 0;
  logic [11:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic [4:0] aux = 0;
  logic [4:0] adet = 5'h1f;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [4:0] pok;
  wire [9:0] dout, dact, dpump;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  logic p;
  logic [31:0] v = 32'hb199;
  logic [31:0] d;
  logic [1:0] r;
  sse_top DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .primary_detect_ok(pok),
    .aux_detect_ok(adet), .aux_dual_input(aux), .driver_output(dout),
    .driver_active(dact), .driver_pump(dpump));
  sse_regulators u_reg (.aclk(aclk), .driver_output(dout),
    .primary_detect_ok(pok));
  initial forever #20 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Compare and count; an unknown bit matches only the same unknown
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Write: both channels offered, each dropped when taken
  task wr(input logic [11:0] a, input logic [31:0] dv);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(d & m, e);
  endtask
  task give_verdict;
    $display("mismatches %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog sized well past the whole sequence
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`SSE_REG_CFG, 32'hffffffff, 0);
    rc(`SSE_REG_DRV_SRC, 32'hffffffff, 0);
    chk(32'(dact), 0);
    rd(12'h3fc);
    chk(32'(r), 32'(`SSE_RESP_SLVERR));
    chk(d, 0);
    wr(12'h3fc, 32'h1);
    chk(32'(r), 32'(`SSE_RESP_SLVERR));
    wr(`SSE_REG_DRV_MODE, 32'h3ff);
    chk(32'(r), 32'(`SSE_RESP_OKAY));
    rc(`SSE_REG_DRV_MODE, 32'h3ff, 32'h3f);
    v = lfsr(v);
    wr(`SSE_REG_DRV_HOST, v);
    wr(`SSE_REG_DRV_SRC, 32'h55555);
    wr(`SSE_REG_CFG, 1);
    repeat (3) @(posedge aclk);
    chk(32'(dout), 32'(v[9:0]));
    chk(32'(dact), 32'h3ff);
    chk(32'(dpump), 32'h3f);
    // Clock source on output 0: 100 kHz is 250 cycles a period
    wr(`SSE_REG_DRV_SRC, 32'h55556);
    n = 0;
    p = 0;
    repeat (2500) begin
      @(posedge aclk);
      if (dout[0] && !p) n++;
      p = dout[0];
    end
    chk(32'(n >= 9 && n <= 11), 1);
    // Aux 0 digital with a 10 us filter; a 6 us glitch must vanish
    wr(`SSE_REG_FILT_BASE, 1);
    wr(`SSE_REG_AUX_MODE, 1);
    wr(`SSE_REG_FILT_BASE + 12'h014, 10);
    aux <= 5'h1;
    repeat (150) @(posedge aclk);
    aux <= 5'h0;
    repeat (400) @(posedge aclk);
    rc(`SSE_REG_INPUTS, 32'h20, 0);
    aux <= 5'h1;
    repeat (400) @(posedge aclk);
    rc(`SSE_REG_INPUTS, 32'h20, 32'h20);
    adet <= 5'h1e;
    repeat (400) @(posedge aclk);
    rc(`SSE_REG_STATUS, 32'h1fc0, 32'h140);
    adet <= 5'h1f;
    // Edge mode, 100 us pulse: high after a falling edge, then low
    wr(`SSE_REG_PULSE, 100);
    wr(`SSE_REG_AUX_MODE, 32'h101);
    aux <= 5'h0;
    repeat (400) @(posedge aclk);
    rc(`SSE_REG_INPUTS, 32'h20, 32'h20);
    repeat (2500) @(posedge aclk);
    rc(`SSE_REG_INPUTS, 32'h20, 0);
    // Cell 0 enables rail 0, waits for it, moves to cell 62
    wr(`SSE_REG_CELL_BASE, 32'h3e10);
    wr(`SSE_REG_CELL_BASE + 12'h008, 1);
    wr(`SSE_REG_CELL_BASE + 12'h3e0, 32'h3e10);
    wr(`SSE_REG_CELL_BASE + 12'h3e8, 32'h2aa);
    wr(`SSE_REG_DRV_SRC, 0);
    wr(`SSE_REG_CTRL, 1);
    repeat (400) @(posedge aclk);
    rc(`SSE_REG_STATUS, 32'h3f, 62);
    chk(32'(dout), 32'h2aa);
    wr(`SSE_REG_CTRL, 32'h3);
    rc(`SSE_REG_STATUS, 32'h3f, 0);
    repeat (400) @(posedge aclk);
    rc(`SSE_REG_STATUS, 32'h3f, 62);
    // Warning through the monitor mask moves cell 62 to cell 61
    wr(`SSE_REG_CELL_BASE + 12'h3d0, 32'h3d1a);
    wr(`SSE_REG_CELL_BASE + 12'h3e0, 32'h3d3e10);
    wr(`SSE_REG_CELL_BASE + 12'h3e8, 32'h40002aa);
    adet <= 5'h1e;
    repeat (150) @(posedge aclk);
    rc(`SSE_REG_STATUS, 32'h3f, 61);
    give_verdict;
  end
endmodule // supply_sequencing_engine_bench
`default_nettype wire
